// >>> common/psl_map.vh
`ifndef PSL_MAP_VH
`define PSL_MAP_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define PSL_LATCHES 6
`define PSL_SYNC_W 15
`define PSL_CNT_W 10
`define PSL_BYTE_LAST 3'h7
// ----------------------------------------
// control port register addresses
// ----------------------------------------
`define PSL_ADDR_MODE 3'h0
`define PSL_ADDR_TXSLOT 3'h1
`define PSL_ADDR_RXSLOT 3'h2
`define PSL_ADDR_DIR 3'h3
`define PSL_ADDR_VAL 3'h4
// ----------------------------------------
// instruction and mode fields
// ----------------------------------------
`define PSL_INSTR_PD 7
`define PSL_INSTR_RD 0
`define PSL_INSTR_ADDR_HI 3
`define PSL_INSTR_ADDR_LO 1
`define PSL_MODE_DELAYED 0
`define PSL_MODE_TXPORT 1
`define PSL_MODE_RXPORT 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define PSL_RST_MODE 3'h0
`define PSL_RST_SLOT 6'h00
`define PSL_RST_DIR 6'h00
`define PSL_RST_VAL 6'h00
`define PSL_RST_PD 1'b1
`define PSL_RST_SYNC 15'h0040
`endif

// >>> hw/psl_sync.v
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// two flip-flop synchroniser
// ----------------------------------------
module psl_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clock,
    input wire rst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q_r
);
    reg [W-1:0] meta_r;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end
endmodule // psl_sync
`default_nettype wire

// >>> hw/psl_slot_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "psl_map.vh"
// ----------------------------------------
// slot window timer from frame sync
// ----------------------------------------
module psl_slot_timer (
    input wire clock,
    input wire rst_n,
    input wire fs_rise,
    input wire bclk_rise,
    input wire delayed,
    input wire [5:0] slot,
    output reg active_r,
    output wire first,
    output wire strobe
);
    reg [`PSL_CNT_W-1:0] cnt_r;
    reg run_r;
    wire [`PSL_CNT_W-1:0] start;
    wire [`PSL_CNT_W-1:0] stop;

    // non-delayed: slot opens at sync; delayed: after 8 x slot bits
    assign start = delayed ? {1'b0, slot, 3'h0} : 10'h000;
    assign stop = start + 10'h008;
    assign first = bclk_rise & run_r & (cnt_r == start);
    assign strobe = bclk_rise & run_r & (cnt_r >= start) & (cnt_r < stop);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {`PSL_CNT_W{1'b0}};
            run_r <= 1'b0;
            active_r <= 1'b0;
        end else if (fs_rise) begin
            cnt_r <= {`PSL_CNT_W{1'b0}};
            run_r <= 1'b1;
            active_r <= 1'b0;
        end else if (bclk_rise && run_r) begin
            cnt_r <= cnt_r + 10'h001;
            if (cnt_r == start) begin
                active_r <= 1'b1;
            end
            if (cnt_r == stop) begin
                active_r <= 1'b0;
                run_r <= 1'b0;
            end
        end
    end
endmodule // psl_slot_timer
`default_nettype wire

// >>> hw/psl_top.v
`timescale 1ns/1ns
`default_nettype none
`include "psl_map.vh"
// Notes on behaviour
// - transmit sync at 8 kHz starts own slot, or frame with slot counter
// - receive sync at 8 kHz starts own slot, or frame with slot counter
// - transmit output driven only in assigned slot on assigned port
// - open-drain slot flag pulls low exactly while its output drives
// - receive input captured on bit clock falls only in assigned slot
// - each latch pin direction follows its latch direction bit
// - input latch levels captured on control reads and shifted out
// - output latch pins driven from written latch value bits
// - control clock shifts data only while chip select is low
// - control clock asynchronous to bit clock and master clock
// - bidirectional control pin turns per current instruction
// - control output changes on rising, input sampled on falling edges
// - one 8-bit word per transmit slot, eight rising edges
// - power-down floats transmit outputs, control and latches stay live
// - reset makes every latch pin an input
module psl_top (
    input wire clock,
    input wire rst_n,
    input wire bit_clock,
    input wire tx_frame_sync,
    input wire rx_frame_sync,
    output reg tx_pcm_out_a,
    output reg tx_pcm_out_a_oe,
    output reg tx_pcm_out_b,
    output reg tx_pcm_out_b_oe,
    output reg tx_slot_flag_n_a,
    output reg tx_slot_flag_n_a_oe,
    output reg tx_slot_flag_n_b,
    output reg tx_slot_flag_n_b_oe,
    input wire rx_pcm_in_a,
    input wire rx_pcm_in_b,
    input wire [7:0] tx_pcm_word,
    output reg tx_pcm_taken,
    output reg [7:0] rx_pcm_word,
    output reg rx_pcm_valid,
    input wire [5:0] slic_latch_pin_i,
    output reg [5:0] slic_latch_pin_o,
    output reg [5:0] slic_latch_pin_oe,
    input wire ctrl_shift_clock,
    input wire ctrl_cs_n,
    input wire ctrl_serial_in,
    output reg ctrl_serial_out,
    output reg ctrl_serial_out_oe,
    input wire ctrl_serial_bidir_i,
    output reg ctrl_serial_bidir_o,
    output reg ctrl_serial_bidir_oe,
    output reg power_down
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    wire [`PSL_SYNC_W-1:0] raw;
    wire [`PSL_SYNC_W-1:0] syn;
    wire bclk_s;
    wire fsx_s;
    wire fsr_s;
    wire rxa_s;
    wire rxb_s;
    wire cs_n_s;
    wire ctrl_shift_clock_s;
    wire cin_s;
    wire [5:0] pins_s;

    assign raw = {slic_latch_pin_i, ctrl_serial_bidir_i, ctrl_serial_in,
        ctrl_cs_n, ctrl_shift_clock, rx_pcm_in_b, rx_pcm_in_a,
        rx_frame_sync, tx_frame_sync, bit_clock};

    psl_sync #(
        .W(`PSL_SYNC_W),
        .RST_VAL(`PSL_RST_SYNC)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d(raw),
        .q_r(syn)
    );

    assign bclk_s = syn[0];
    assign fsx_s = syn[1];
    assign fsr_s = syn[2];
    assign rxa_s = syn[3];
    assign rxb_s = syn[4];
    assign ctrl_shift_clock_s = syn[5];
    assign cs_n_s = syn[6];
    // unused control input is tied low by the board
    assign cin_s = syn[7] | syn[8];
    assign pins_s = syn[14:9];

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    reg bclk_d_r;
    reg fsx_d_r;
    reg fsr_d_r;
    reg ctrl_shift_clock_d_r;
    wire bclk_rise;
    wire bclk_fall;
    wire fsx_rise;
    wire fsr_rise;
    wire ctrl_shift_clock_rise;
    wire ctrl_shift_clock_fall;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bclk_d_r <= 1'b0;
            fsx_d_r <= 1'b0;
            fsr_d_r <= 1'b0;
            ctrl_shift_clock_d_r <= 1'b0;
        end else begin
            bclk_d_r <= bclk_s;
            fsx_d_r <= fsx_s;
            fsr_d_r <= fsr_s;
            ctrl_shift_clock_d_r <= ctrl_shift_clock_s;
        end
    end

    assign bclk_rise = bclk_s & ~bclk_d_r;
    assign bclk_fall = ~bclk_s & bclk_d_r;
    assign fsx_rise = fsx_s & ~fsx_d_r;
    assign fsr_rise = fsr_s & ~fsr_d_r;
    assign ctrl_shift_clock_rise = ctrl_shift_clock_s & ~ctrl_shift_clock_d_r;
    assign ctrl_shift_clock_fall = ~ctrl_shift_clock_s & ctrl_shift_clock_d_r;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    reg [2:0] mode_r;
    reg [5:0] tx_slot_r;
    reg [5:0] rx_slot_r;
    reg [5:0] dir_r;
    reg [5:0] val_r;

    // ----------------------------------------
    // slot timers
    // ----------------------------------------
    wire tx_active;
    wire tx_first;
    wire tx_strobe;
    wire rx_active;

    psl_slot_timer u_tx_timer (
        .clock(clock),
        .rst_n(rst_n),
        .fs_rise(fsx_rise),
        .bclk_rise(bclk_rise),
        .delayed(mode_r[`PSL_MODE_DELAYED]),
        .slot(tx_slot_r),
        .active_r(tx_active),
        .first(tx_first),
        .strobe(tx_strobe)
    );

    psl_slot_timer u_rx_timer (
        .clock(clock),
        .rst_n(rst_n),
        .fs_rise(fsr_rise),
        .bclk_rise(bclk_rise),
        .delayed(mode_r[`PSL_MODE_DELAYED]),
        .slot(rx_slot_r),
        .active_r(rx_active),
        .first(),
        .strobe()
    );

    // ----------------------------------------
    // transmit shifter
    // ----------------------------------------
    reg [7:0] tx_sh_r;
    wire tx_on;
    wire tx_port_b;

    assign tx_port_b = mode_r[`PSL_MODE_TXPORT];
    assign tx_on = tx_strobe & ~power_down;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_r <= 8'h00;
            tx_pcm_out_a <= 1'b0;
            tx_pcm_out_b <= 1'b0;
            tx_pcm_out_a_oe <= 1'b0;
            tx_pcm_out_b_oe <= 1'b0;
            tx_slot_flag_n_a <= 1'b0;
            tx_slot_flag_n_b <= 1'b0;
            tx_slot_flag_n_a_oe <= 1'b0;
            tx_slot_flag_n_b_oe <= 1'b0;
            tx_pcm_taken <= 1'b0;
        end else begin
            tx_pcm_taken <= tx_first & ~power_down;
            if (tx_on && tx_first) begin
                tx_pcm_out_a <= tx_pcm_word[7];
                tx_pcm_out_b <= tx_pcm_word[7];
                tx_sh_r <= {tx_pcm_word[6:0], 1'b0};
            end else if (tx_on) begin
                tx_pcm_out_a <= tx_sh_r[7];
                tx_pcm_out_b <= tx_sh_r[7];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
            if (bclk_rise || power_down) begin
                tx_pcm_out_a_oe <= tx_on & ~tx_port_b;
                tx_pcm_out_b_oe <= tx_on & tx_port_b;
                tx_slot_flag_n_a_oe <= tx_on & ~tx_port_b;
                tx_slot_flag_n_b_oe <= tx_on & tx_port_b;
            end
        end
    end

    // ----------------------------------------
    // receive shifter
    // ----------------------------------------
    reg [7:0] rx_sh_r;
    reg [2:0] rx_cnt_r;
    wire rx_bit;

    assign rx_bit = mode_r[`PSL_MODE_RXPORT] ? rxb_s : rxa_s;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            rx_pcm_word <= 8'h00;
            rx_pcm_valid <= 1'b0;
        end else begin
            rx_pcm_valid <= 1'b0;
            if (!rx_active) begin
                rx_cnt_r <= 3'h0;
            end else if (bclk_fall) begin
                rx_sh_r <= {rx_sh_r[6:0], rx_bit};
                rx_cnt_r <= rx_cnt_r + 3'h1;
                if (rx_cnt_r == `PSL_BYTE_LAST) begin
                    rx_pcm_word <= {rx_sh_r[6:0], rx_bit};
                    rx_pcm_valid <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // control port
    // ----------------------------------------
    localparam C_INSTR = 2'h0;
    localparam C_DATA = 2'h1;
    localparam C_DONE = 2'h2;

    reg [1:0] cstate_r;
    reg [7:0] csh_r;
    reg [7:0] cout_r;
    reg [2:0] cbit_r;
    reg [2:0] caddr_r;
    reg crd_r;
    reg [7:0] rd_val;
    wire [7:0] cin_byte;
    wire [5:0] sensed;

    assign cin_byte = {csh_r[6:0], cin_s};
    // input pins read live, output pins read the written value
    assign sensed = (dir_r & val_r) | (~dir_r & pins_s);

    always @* begin
        case (cin_byte[`PSL_INSTR_ADDR_HI:`PSL_INSTR_ADDR_LO])
            `PSL_ADDR_MODE: rd_val = {5'h00, mode_r};
            `PSL_ADDR_TXSLOT: rd_val = {2'h0, tx_slot_r};
            `PSL_ADDR_RXSLOT: rd_val = {2'h0, rx_slot_r};
            `PSL_ADDR_DIR: rd_val = {2'h0, dir_r};
            `PSL_ADDR_VAL: rd_val = {2'h0, sensed};
            default: rd_val = 8'h00;
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cstate_r <= C_INSTR;
            csh_r <= 8'h00;
            cout_r <= 8'h00;
            cbit_r <= 3'h0;
            caddr_r <= 3'h0;
            crd_r <= 1'b0;
            power_down <= `PSL_RST_PD;
            mode_r <= `PSL_RST_MODE;
            tx_slot_r <= `PSL_RST_SLOT;
            rx_slot_r <= `PSL_RST_SLOT;
            dir_r <= `PSL_RST_DIR;
            val_r <= `PSL_RST_VAL;
            ctrl_serial_out <= 1'b0;
            ctrl_serial_out_oe <= 1'b0;
            ctrl_serial_bidir_o <= 1'b0;
            ctrl_serial_bidir_oe <= 1'b0;
        end else if (cs_n_s) begin
            cstate_r <= C_INSTR;
            cbit_r <= 3'h0;
            crd_r <= 1'b0;
            ctrl_serial_out_oe <= 1'b0;
            ctrl_serial_bidir_oe <= 1'b0;
        end else begin
            if (ctrl_shift_clock_rise && crd_r) begin
                ctrl_serial_out <= cout_r[7];
                ctrl_serial_bidir_o <= cout_r[7];
                ctrl_serial_out_oe <= 1'b1;
                ctrl_serial_bidir_oe <= 1'b1;
                cout_r <= {cout_r[6:0], 1'b0};
            end
            if (ctrl_shift_clock_fall) begin
                csh_r <= cin_byte;
                cbit_r <= cbit_r + 3'h1;
                case (cstate_r)
                    C_INSTR: begin
                        if (cbit_r == `PSL_BYTE_LAST) begin
                            power_down <= cin_byte[`PSL_INSTR_PD];
                            caddr_r <= cin_byte[`PSL_INSTR_ADDR_HI:
                                `PSL_INSTR_ADDR_LO];
                            crd_r <= cin_byte[`PSL_INSTR_RD];
                            cout_r <= rd_val;
                            cstate_r <= C_DATA;
                        end
                    end
                    C_DATA: begin
                        if (cbit_r == `PSL_BYTE_LAST) begin
                            cstate_r <= C_DONE;
                            if (!crd_r) begin
                                case (caddr_r)
                                    `PSL_ADDR_MODE: mode_r <= cin_byte[2:0];
                                    `PSL_ADDR_TXSLOT:
                                        tx_slot_r <= cin_byte[5:0];
                                    `PSL_ADDR_RXSLOT:
                                        rx_slot_r <= cin_byte[5:0];
                                    `PSL_ADDR_DIR: dir_r <= cin_byte[5:0];
                                    `PSL_ADDR_VAL: val_r <= cin_byte[5:0];
                                    default: val_r <= val_r;
                                endcase
                            end
                        end
                    end
                    C_DONE: cbit_r <= 3'h0;
                    default: begin
                        cstate_r <= C_INSTR;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // interface latch pins
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slic_latch_pin_o <= 6'h00;
            slic_latch_pin_oe <= 6'h00;
        end else begin
            slic_latch_pin_oe <= dir_r;
            slic_latch_pin_o <= val_r;
        end
    end
endmodule // psl_top
`default_nettype wire

// >>> tb/psl_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker for the slot, latch and control ports
// ----------------------------------------
module psl_top_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tx_pcm_out_a_oe,
    input wire logic tx_pcm_out_b_oe,
    input wire logic tx_slot_flag_n_a,
    input wire logic tx_slot_flag_n_a_oe,
    input wire logic tx_slot_flag_n_b,
    input wire logic tx_slot_flag_n_b_oe,
    input wire logic tx_pcm_taken,
    input wire logic rx_pcm_valid,
    input wire logic [5:0] slic_latch_pin_oe,
    input wire logic ctrl_cs_n,
    input wire logic ctrl_serial_out_oe,
    input wire logic ctrl_serial_bidir_oe,
    input wire logic power_down
);
    wire logic any_oe = tx_pcm_out_a_oe | tx_pcm_out_b_oe;
    logic [7:0] hi_r;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            hi_r <= 8'h00;
        else if (any_oe)
            hi_r <= hi_r + 8'h01;
        else
            hi_r <= 8'h00;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_flag_a;
        tx_slot_flag_n_a_oe == tx_pcm_out_a_oe;
    endproperty
    a_flag_a: assert property (p_flag_a)
        else $error("slot flag a differs from tx a enable");
    property p_flag_b;
        tx_slot_flag_n_b_oe == tx_pcm_out_b_oe;
    endproperty
    a_flag_b: assert property (p_flag_b)
        else $error("slot flag b differs from tx b enable");
    property p_flag_lvl;
        !tx_slot_flag_n_a && !tx_slot_flag_n_b;
    endproperty
    a_flag_lvl: assert property (p_flag_lvl)
        else $error("slot flag value not low");
    property p_one_port;
        !(tx_pcm_out_a_oe && tx_pcm_out_b_oe);
    endproperty
    a_one_port: assert property (p_one_port)
        else $error("both tx ports driven");
    property p_pd_quiet;
        power_down && $past(power_down) |-> !any_oe;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet)
        else $error("tx driven in power down");
    property p_width;
        $fell(any_oe) |-> hi_r >= 8'h3F && hi_r <= 8'h41;
    endproperty
    a_width: assert property (p_width)
        else $error("tx slot not eight bit periods");
    property p_taken;
        $rose(any_oe) |-> ##[0:2] tx_pcm_taken;
    endproperty
    a_taken: assert property (p_taken)
        else $error("no word taken at slot start");
    property p_dir_rst;
        !$past(rst_n) |-> slic_latch_pin_oe == 6'h00;
    endproperty
    a_dir_rst: assert property (p_dir_rst)
        else $error("latch pins not inputs after reset");
    property p_cs_idle;
        ctrl_cs_n [*5] |-> !ctrl_serial_out_oe;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("control output driven without select");
    property p_bidir;
        ctrl_serial_bidir_oe == ctrl_serial_out_oe;
    endproperty
    a_bidir: assert property (p_bidir)
        else $error("bidir pin direction differs");
    property p_rx_pulse;
        rx_pcm_valid |=> !rx_pcm_valid;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("rx valid longer than one cycle");
    c_tx_a: cover property ($rose(tx_pcm_out_a_oe));
    c_tx_b: cover property ($rose(tx_pcm_out_b_oe));
    c_rx: cover property (rx_pcm_valid);
    c_read: cover property (ctrl_serial_out_oe);
endmodule // psl_top_asserts
`default_nettype wire

// >>> tb/psl_pcm_far.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// pcm backplane model
// ----------------------------------------
module psl_pcm_far (
    output logic bit_clock,
    output logic tx_frame_sync,
    output logic rx_frame_sync,
    output logic rx_pcm_in_a,
    output logic rx_pcm_in_b,
    input wire logic tx_pcm_out_a,
    input wire logic tx_pcm_out_a_oe,
    input wire logic tx_pcm_out_b,
    input wire logic tx_pcm_out_b_oe
);
    logic rxd = 1'b0;
    logic [7:0] got = 8'h00;
    int na = 0;
    int nb = 0;
    assign rx_pcm_in_a = rxd;
    assign rx_pcm_in_b = ~rxd;
    initial begin
        bit_clock = 1'b0;
        tx_frame_sync = 1'b0;
        rx_frame_sync = 1'b0;
        #12;
        forever #80 bit_clock = ~bit_clock;
    end
    // capture only bits whose pin is driven
    always @(posedge bit_clock) begin
        if (tx_pcm_out_a_oe === 1'b1) begin
            got <= {got[6:0], tx_pcm_out_a};
            na <= na + 1;
        end
        if (tx_pcm_out_b_oe === 1'b1) begin
            got <= {got[6:0], tx_pcm_out_b};
            nb <= nb + 1;
        end
    end
    task automatic frame(input logic [7:0] rxb, input int rs);
        @(negedge bit_clock);
        tx_frame_sync = 1'b1;
        rx_frame_sync = 1'b1;
        for (int i = 0; i < 34; i++) begin
            @(posedge bit_clock);
            if (i == 1) begin
                tx_frame_sync = 1'b0;
                rx_frame_sync = 1'b0;
            end
            // byte in its slot, toggling elsewhere
            rxd = (i >= rs && i < rs + 8) ? rxb[7 - (i - rs)] : ~rxd;
        end
    endtask
endmodule // psl_pcm_far
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] tx_pcm_word = 8'h00;
    logic ctrl_shift_clock = 1'b1;
    logic ctrl_cs_n = 1'b1;
    logic ctrl_serial_in = 1'b0;
    logic [5:0] pin_ext = 6'h15;
    logic [7:0] rd, rdb, rx_seen, da, db, dk, dr;
    int error_cnt = 0;
    int total_checks = 0;
    int rx_cnt = 0;
    int tk_cnt = 0;
    wire bit_clock, tx_frame_sync, rx_frame_sync, rx_pcm_in_a, rx_pcm_in_b;
    wire tx_pcm_out_a, tx_pcm_out_a_oe, tx_pcm_out_b, tx_pcm_out_b_oe;
    wire tx_pcm_taken, rx_pcm_valid, ctrl_serial_out, power_down;
    wire ctrl_serial_out_oe, ctrl_serial_bidir_o, ctrl_serial_bidir_oe;
    wire [7:0] rx_pcm_word;
    wire [5:0] slic_latch_pin_o, slic_latch_pin_oe;
    wire [5:0] slic_i = (slic_latch_pin_o & slic_latch_pin_oe) |
        (pin_ext & ~slic_latch_pin_oe);
    psl_top dut_u (.clock, .rst_n, .bit_clock, .tx_frame_sync,
        .rx_frame_sync, .tx_pcm_out_a, .tx_pcm_out_a_oe, .tx_pcm_out_b,
        .tx_pcm_out_b_oe, .tx_slot_flag_n_a(), .tx_slot_flag_n_a_oe(),
        .tx_slot_flag_n_b(), .tx_slot_flag_n_b_oe(), .rx_pcm_in_a,
        .rx_pcm_in_b, .tx_pcm_word, .tx_pcm_taken, .rx_pcm_word,
        .rx_pcm_valid, .slic_latch_pin_i(slic_i), .slic_latch_pin_o,
        .slic_latch_pin_oe, .ctrl_shift_clock, .ctrl_cs_n, .ctrl_serial_in,
        .ctrl_serial_out, .ctrl_serial_out_oe, .ctrl_serial_bidir_i(1'b0),
        .ctrl_serial_bidir_o, .ctrl_serial_bidir_oe, .power_down);
    psl_pcm_far far_u (.bit_clock, .tx_frame_sync, .rx_frame_sync,
        .rx_pcm_in_a, .rx_pcm_in_b, .tx_pcm_out_a, .tx_pcm_out_a_oe,
        .tx_pcm_out_b, .tx_pcm_out_b_oe);
    always #10 clock = ~clock;
    always @(posedge clock) begin
        if (rx_pcm_valid === 1'b1) begin
            rx_cnt++;
            rx_seen = rx_pcm_word;
        end
        if (tx_pcm_taken === 1'b1)
            tk_cnt++;
    end
    task tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (error_cnt == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // host transfer: instruction byte then data byte, read data kept
    task xfer(input logic [7:0] ins, input logic [7:0] wd);
        logic [15:0] sh;
        sh = {ins, wd};
        rd = 8'h00;
        rdb = 8'h00;
        ctrl_cs_n = 1'b0;
        tick(4);
        for (int k = 0; k < 16; k++) begin
            ctrl_serial_in = sh[15 - k];
            tick(4);
            // a released pin reads as its pull-up level
            if (k >= 8) begin
                rd = {rd[6:0], ctrl_serial_out_oe ? ctrl_serial_out : 1'b1};
                rdb = {rdb[6:0],
                    ctrl_serial_bidir_oe ? ctrl_serial_bidir_o : 1'b1};
            end
            ctrl_shift_clock = 1'b0;
            tick(4);
            ctrl_shift_clock = 1'b1;
        end
        tick(4);
        ctrl_cs_n = 1'b1;
        ctrl_serial_in = 1'b0;
        tick(8);
    endtask
    task run_frame(input logic [7:0] tw, input logic [7:0] rxb, input int rs);
        int a0, b0, k0, r0;
        a0 = far_u.na;
        b0 = far_u.nb;
        k0 = tk_cnt;
        r0 = rx_cnt;
        tx_pcm_word = tw;
        far_u.frame(rxb, rs);
        tick(20);
        da = 8'(far_u.na - a0);
        db = 8'(far_u.nb - b0);
        dk = 8'(tk_cnt - k0);
        dr = 8'(rx_cnt - r0);
    endtask
    task t_reset;
        chk({1'b0, power_down, slic_latch_pin_oe}, 8'h40);
    endtask
    task t_latch;
        xfer(8'h06, 8'h0F);
        xfer(8'h08, 8'h2A);
        chk({2'h0, slic_latch_pin_oe}, 8'h0F);
        chk({2'h0, slic_latch_pin_o}, 8'h2A);
        xfer(8'h09, 8'h00);
        chk(rd, 8'h1A);
        chk(rdb, 8'h1A);
        chk({7'h00, power_down}, 8'h00);
    endtask
    task t_tx_nd;
        xfer(8'h00, 8'h00);
        run_frame(8'hA5, 8'h3C, 0);
        chk(far_u.got, 8'hA5);
        chk(da, 8'h08);
        chk(db, 8'h00);
        chk(dk, 8'h01);
        chk(dr, 8'h01);
        chk(rx_seen, 8'h3C);
    endtask
    task t_tx_dl;
        xfer(8'h00, 8'h07);
        xfer(8'h02, 8'h02);
        xfer(8'h04, 8'h03);
        run_frame(8'h96, 8'h3C, 24);
        chk(far_u.got, 8'h96);
        chk(db, 8'h08);
        chk(da, 8'h00);
        chk(dr, 8'h01);
        chk(rx_seen, 8'hC3);
        chk(dk, 8'h01);
    endtask
    task t_pd;
        xfer(8'h86, 8'h0F);
        chk({7'h00, power_down}, 8'h01);
        run_frame(8'h5A, 8'h3C, 24);
        chk(da + db, 8'h00);
        chk(dk, 8'h00);
        chk({2'h0, slic_latch_pin_oe}, 8'h0F);
        chk({2'h0, slic_latch_pin_o}, 8'h2A);
    endtask
    initial begin
        tick(10);
        rst_n = 1'b1;
        tick(2);
        t_reset;
        t_latch;
        t_tx_nd;
        t_tx_dl;
        t_pd;
        end_sim;
    end
    initial begin
        #400000;
        error_cnt++;
        end_sim;
    end
endmodule // testbench
bind psl_top psl_top_asserts chk_u (.clock, .rst_n, .tx_pcm_out_a_oe,
    .tx_pcm_out_b_oe, .tx_slot_flag_n_a, .tx_slot_flag_n_a_oe,
    .tx_slot_flag_n_b, .tx_slot_flag_n_b_oe, .tx_pcm_taken, .rx_pcm_valid,
    .slic_latch_pin_oe, .ctrl_cs_n, .ctrl_serial_out_oe,
    .ctrl_serial_bidir_oe, .power_down);
`default_nettype wire
